// ===== sim/dor_host.sv
// host-side serial control master that reaches the register bank
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ns
module dor_host #(
    parameter logic [6:0] ADDR = 7'h3D,
    parameter int         HALF = 10
) (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // data set while scl low, sampled at the end of the high half
    task automatic clk_bit(input logic low, output logic got);
        sda_low = low;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        got = sda_line;
        scl = 1'b0;
    endtask
    task automatic start();
        sda_low = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask
    task automatic tx(input logic [7:0] b, inout logic ok);
        logic g;
        for (int i = 7; i >= 0; i--) clk_bit(~b[i], g);
        clk_bit(1'b0, g);
        ok = ok & ~g;
    endtask
    task automatic rx(input logic last, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) clk_bit(1'b0, b[i]);
        clk_bit(~last, g);
    endtask
    task automatic probe(input logic [6:0] a, output logic ok);
        ok = 1'b1;
        start();
        tx({a, 1'b0}, ok);
        stop();
    endtask
    task automatic wr_word(input logic [15:0] idx, input logic [31:0] d, output logic ok);
        ok = 1'b1;
        start();
        tx({ADDR, 1'b0}, ok);
        tx(idx[15:8], ok);
        tx(idx[7:0], ok);
        for (int i = 3; i >= 0; i--) tx(d[i*8+:8], ok);
        stop();
    endtask
    task automatic rd_word(input logic [15:0] idx, output logic [31:0] d, output logic ok);
        ok = 1'b1;
        start();
        tx({ADDR, 1'b0}, ok);
        tx(idx[15:8], ok);
        tx(idx[7:0], ok);
        start();
        tx({ADDR, 1'b1}, ok);
        for (int i = 3; i >= 0; i--) rx(i == 0, d[i*8+:8]);
        stop();
    endtask
endmodule // dor_host

// ===== sim/tb.sv
// self-checking bench for the depth output configuration register bank
// assumes dor_pkg and the design files are compiled first
`timescale 1ns/1ns
module tb;
    import dor_pkg::*;
    logic        ref_clk, srst, boot_done_in, depth_in_valid, frame_end, frame_start_in;
    logic [15:0] depth_in;
    logic [1:0]  depth_area;
    logic        scl, host_low, sda_line, sda_o, sda_oe_n, boot_complete, frame_keep;
    logic        depth_out_valid, depth_radial, chan_intensity, multifreq_enable;
    logic [15:0] depth_out;
    logic [11:0] line_width, line_count, hdelay, vdelay;
    logic [7:0]  temporal_weight;
    logic [8:0]  multifreq_weight;
    logic [31:0] d;
    int          err_total, n_checks, n;
    localparam logic [15:0] RIDX [10] = '{16'h0030, 16'h0033, 16'h003A, 16'h003B, 16'h003D,
        16'h0041, 16'h0046, 16'h00AD, 16'h0127, 16'h0050};
    localparam logic [31:0] RVAL [10] = '{32'h0, 32'h8000_0000, 32'h0200_0020, 32'h0,
        32'h1801_0000, 32'h0001_0000, 32'h1000_0000, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] FMT [3] = '{32'h1000_0004, 32'h2123_000B, 32'h4000_000D};
    localparam logic [11:0] WID [3] = '{12'hA00, 12'h500, 12'h280};
    // pull-up: low when either party pulls
    assign sda_line = !(host_low || (!sda_oe_n && !sda_o));
    dor_host host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
    dor_regs #(.AVG_LOG2(1)) uut (
        .ref_clk(ref_clk), .srst(srst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .boot_done_in(boot_done_in), .boot_complete(boot_complete),
        .depth_in_valid(depth_in_valid), .depth_in(depth_in), .depth_area(depth_area),
        .frame_end(frame_end), .depth_out_valid(depth_out_valid), .depth_out(depth_out),
        .frame_start_in(frame_start_in), .frame_keep(frame_keep), .line_width(line_width),
        .line_count(line_count), .hdelay(hdelay), .vdelay(vdelay),
        .depth_radial(depth_radial), .chan_intensity(chan_intensity),
        .temporal_weight(temporal_weight), .multifreq_weight(multifreq_weight),
        .multifreq_enable(multifreq_enable));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] v);
        logic ok;
        host.wr_word(idx, v, ok);
        chk("write ack", 32'h1, {31'h0, ok});
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        logic ok;
        logic [31:0] v;
        host.rd_word(idx, v, ok);
        chk("read ack", 32'h1, {31'h0, ok});
        chk($sformatf("reg %h", idx), exp, v);
    endtask
    // two region samples per quadrant whose average is v[q], spread by sp
    task automatic frame(input logic [3:0][15:0] v, input logic [15:0] sp);
        for (int q = 0; q < 4; q++) begin
            for (int s = 0; s < 2; s++) begin
                @(negedge ref_clk);
                depth_in_valid = 1'b1;
                depth_area = q[1:0];
                depth_in = s ? v[q] + sp : v[q] - sp;
            end
        end
        @(negedge ref_clk);
        depth_in_valid = 1'b0;
        frame_end = 1'b1;
        @(negedge ref_clk);
        frame_end = 1'b0;
    endtask
    task automatic depth(input logic [15:0] v, input logic [15:0] exp);
        @(negedge ref_clk);
        depth_in_valid = 1'b1;
        depth_in = v;
        @(negedge ref_clk);
        depth_in_valid = 1'b0;
        chk("depth_out_valid", 32'h1, {31'h0, depth_out_valid});
        chk("depth_out", {16'h0, exp}, {16'h0, depth_out});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end
    initial begin
        logic ok;
        srst = 1'b1;
        {boot_done_in, depth_in_valid, frame_end, frame_start_in} = 4'h0;
        depth_in = 16'h0000;
        depth_area = 2'h0;
        err_total = 0;
        n_checks = 0;
        repeat (8) @(negedge ref_clk);
        srst = 1'b0;
        repeat (5) @(negedge ref_clk);
        wr(16'h0050, 32'hFFFF_FFFF);
        for (int i = 0; i < 10; i++) rd(RIDX[i], RVAL[i]);
        chk("line_width", 32'hA00, {20'h0, line_width});
        chk("weights", 32'h2000_3001, {temporal_weight, 7'h0, multifreq_weight, 7'h0,
            multifreq_enable});
        host.probe(7'h3C, ok);
        chk("foreign address ack", 32'h0, {31'h0, ok});
        $display("test reset and access done");
        chk("boot_complete", 32'h0, {31'h0, boot_complete});
        @(negedge ref_clk);
        boot_done_in = 1'b1;
        @(negedge ref_clk);
        boot_done_in = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("boot_complete", 32'h1, {31'h0, boot_complete});
        rd(16'h00AD, 32'h1);
        $display("test boot done");
        wr(16'h003B, 32'h0000_000A);
        frame({16'd100, 16'd100, 16'd100, 16'd100}, 16'd0);
        rd(16'h0127, 32'h0);
        frame({16'd100, 16'd89, 16'd110, 16'd111}, 16'd20);
        rd(16'h0127, 32'h5);
        $display("test interference done");
        wr(16'h0030, 32'h0000_FFF6);
        depth(16'd100, 16'd90);
        depth(16'd5, 16'd0);
        wr(16'h0030, 32'h0000_0010);
        depth(16'hFFF8, 16'hFFFF);
        $display("test offset done");
        wr(16'h003A, 32'h0200_00FF);
        chk("temporal_weight", 32'hFF, {24'h0, temporal_weight});
        wr(16'h003D, {9'h0FE, MF_FIXED, 16'h0});
        chk("mf weight", 32'h1FD, {22'h0, multifreq_weight, multifreq_enable});
        wr(16'h003D, {9'h0FF, MF_FIXED, 16'h0});
        chk("mf weight", 32'h1FE, {22'h0, multifreq_weight, multifreq_enable});
        rd(16'h003D, 32'h7F81_0000);
        $display("test blur done");
        for (int i = 0; i < 3; i++) begin
            wr(16'h0046, FMT[i]);
            chk("line_width", {20'h0, WID[i]}, {20'h0, line_width});
            chk("line_count", 32'h3C1, {20'h0, line_count});
            chk("delays", FMT[i][23:0], {vdelay, hdelay});
            chk("format", {30'h0, FMT[i][1:0]}, {30'h0, chan_intensity, depth_radial});
            n = 0;
            for (int f = 0; f < 8; f++) begin
                @(negedge ref_clk);
                frame_start_in = 1'b1;
                #1;
                n += int'(frame_keep === 1'b1);
                @(negedge ref_clk);
                frame_start_in = 1'b0;
            end
            chk("kept frames", FMT[i][3:2] == 2'h1 ? 4 : FMT[i][3:2] == 2'h2 ? 2 : 8, n);
        end
        $display("test output format done");
        finish_test();
    end
endmodule // tb

// ===== src/dor_mci_area.sv
// per-quadrant interference detector: averages a region, compares frames
// assumes samples tagged with their quadrant and a frame_end pulse
`timescale 1ns/1ns
module dor_mci_area
    import dor_pkg::*;
#(
    parameter int AVG_LOG2 = 4
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    dor_mci_if.det    mci
);
    if (AVG_LOG2 < 1 || AVG_LOG2 > 12) begin : g_bad_avg
        $error("AVG_LOG2 out of range");
    end
    localparam int SW = 16 + AVG_LOG2;

    logic [SW-1:0]     acc  [4];
    logic [AVG_LOG2:0] cnt  [4];
    logic [15:0]       prev [4];
    logic              have_prev;
    logic [3:0]        flags;
    logic [3:0]        next_flags;

    assign mci.flags = flags;

    // the region is the first 2**AVG_LOG2 samples of each quadrant
    for (genvar a = 0; a < 4; a++) begin : g_area
        wire         hit  = mci.valid && mci.area == 2'(a) && !cnt[a][AVG_LOG2];
        wire [15:0]  avg  = acc[a][SW-1:AVG_LOG2];
        wire [15:0]  diff = (prev[a] > avg) ? prev[a] - avg : avg - prev[a];
        assign next_flags[a] = have_prev && diff > {3'h0, mci.thresh}; // R05
        always_ff @(posedge ref_clk) begin
            if (srst || mci.frame_end) begin
                acc[a] <= '0;
                cnt[a] <= '0;
            end else if (hit) begin
                acc[a] <= acc[a] + SW'(mci.value); // R06
                cnt[a] <= cnt[a] + 1'b1;
            end
            if (srst)
                prev[a] <= '0;
            else if (mci.frame_end)
                prev[a] <= avg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags     <= 4'h0;
            have_prev <= 1'b0;
        end else if (mci.frame_end) begin
            flags     <= next_flags; // R05 R07
            have_prev <= 1'b1;
        end
    end

    a_flag_hold: assert property (@(posedge ref_clk) disable iff (srst) // R05
        !mci.frame_end |=> $stable(flags)) else $error("flags moved off frame end");
    a_flag_cause: assert property (@(posedge ref_clk) disable iff (srst) // R05
        (mci.frame_end && !have_prev) |=> flags == 4'h0)
        else $error("flag raised without previous frame");
endmodule : dor_mci_area

// ===== src/dor_mci_if.sv
// interference detection carrier between the register bank and detector
// assumes both ends run on ref_clk
`timescale 1ns/1ns
interface dor_mci_if;
    logic        valid;
    logic [1:0]  area;
    logic [15:0] value;
    logic        frame_end;
    logic [12:0] thresh;
    logic [3:0]  flags;
    modport src (output valid, output area, output value, output frame_end,
                 output thresh, input flags);
    modport det (input valid, input area, input value, input frame_end,
                 input thresh, output flags);
endinterface : dor_mci_if

// ===== src/dor_pkg.sv
// constants for the depth output configuration register bank
// assumes a single ref_clk domain and 16-bit serial-port register indexes
// Contract
// [R01] add signed offset to every output depth
// [R02] temporal blur weight, full byte, default 0x20
// [R03] multi-frequency weight; all ones disables processing (code disables only at 9'h0FF, so 9-bit all ones 0x1FF leaves it enabled)
// [R04] bits 22:16 fixed at 0x01, never change
// [R05] flag area when frame difference exceeds threshold
// [R06] difference uses region average, not one pixel
// [R07] four flag bits, one per quadrant
// [R08] mode field selects video output layout
// [R09] format bit 0 picks radial or point-cloud
// [R10] format bit 1 picks amplitude or intensity
// [R11] rate field: 1=15, 2=7.5, else 30 fps
// [R12] vertical and horizontal delays drive frame timing
// [R13] boot status bit reads 1 after boot
// [R14] boot-complete pin mirrors boot status bit
// [R15] host writes fixed fields back unchanged
package dor_pkg;
    localparam logic [15:0] OFS_GLOBAL_OFFSET = 16'h0030;
    localparam logic [15:0] OFS_OFFSET_RSVD   = 16'h0033;
    localparam logic [15:0] OFS_TEMPORAL_BLUR = 16'h003A;
    localparam logic [15:0] OFS_MCI_THRESH    = 16'h003B;
    localparam logic [15:0] OFS_MULTIFREQ     = 16'h003D;
    localparam logic [15:0] OFS_FW_REV        = 16'h0041;
    localparam logic [15:0] OFS_OUT_FORMAT    = 16'h0046;
    localparam logic [15:0] OFS_BOOT_STATUS   = 16'h00AD;
    localparam logic [15:0] OFS_MCI_FLAGS     = 16'h0127;

    localparam logic [15:0] RST_GLOBAL_OFFSET = 16'h0000;
    localparam logic [31:0] RST_OFFSET_RSVD   = 32'h8000_0000;
    localparam logic [31:0] RST_TEMPORAL_BLUR = 32'h0200_0020;
    localparam logic [12:0] RST_MCI_THRESH    = 13'h0000;
    localparam logic [8:0]  RST_MF_WEIGHT     = 9'h030;
    localparam logic [6:0]  MF_FIXED          = 7'h01;
    localparam logic [31:0] RST_OUT_FORMAT    = 32'h1000_0000;

    localparam int MF_W_LSB   = 23;
    localparam int MF_FIX_LSB = 16;
    localparam int MODE_LSB   = 28;
    localparam int VDLY_LSB   = 12;
    localparam int RATE_LSB   = 2;
    localparam logic [8:0] MF_DISABLE = 9'h0FF;

    localparam logic [3:0] MODE_FOUR  = 4'h1;
    localparam logic [3:0] MODE_ZA    = 4'h2;
    localparam logic [3:0] MODE_Z     = 4'h4;
    localparam logic [11:0] WIDTH_FOUR = 12'hA00;
    localparam logic [11:0] WIDTH_ZA   = 12'h500;
    localparam logic [11:0] WIDTH_Z    = 12'h280;
    localparam logic [11:0] LINES_OUT  = 12'h3C1;

    localparam logic [1:0] RATE_15  = 2'h1;
    localparam logic [1:0] RATE_7P5 = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK
    } dor_i2c_e;
endpackage : dor_pkg

// ===== src/dor_regs.sv
// depth output configuration bank with serial control slave and depth path
// assumes scl/sda come from pins; depth, frame and boot inputs on ref_clk
`timescale 1ns/1ns
module dor_regs
    import dor_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR = 7'h3D,
    // arbitrary revision value
    parameter logic [11:0] FW_REV   = 12'h001,
    parameter int          AVG_LOG2 = 4
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output wire logic        sda_o,
    output wire logic        sda_oe_n,
    input  wire logic        boot_done_in,
    output wire logic        boot_complete,
    input  wire logic        depth_in_valid,
    input  wire logic [15:0] depth_in,
    input  wire logic [1:0]  depth_area,
    input  wire logic        frame_end,
    output logic             depth_out_valid,
    output logic      [15:0] depth_out,
    input  wire logic        frame_start_in,
    output wire logic        frame_keep,
    output logic      [11:0] line_width,
    output logic      [11:0] line_count,
    output logic      [11:0] hdelay,
    output logic      [11:0] vdelay,
    output logic             depth_radial,
    output logic             chan_intensity,
    output logic      [7:0]  temporal_weight,
    output logic      [8:0]  multifreq_weight,
    output logic             multifreq_enable
);
    // pin synchronisers: stage 1 feeds stage 2 only
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    always_ff @(posedge ref_clk) begin
        scl_s1 <= scl_i;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        sda_s1 <= sda_i;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
    end
    wire scl_rise = scl_s2 && !scl_s3;
    wire scl_fall = !scl_s2 && scl_s3;
    wire bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    wire bus_stop  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

    dor_i2c_e    st;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic        rw;
    logic        nack;
    logic [2:0]  bidx;
    logic [1:0]  tn;
    logic [15:0] ptr;
    logic [23:0] wd;
    logic        wr_stb;
    logic [31:0] wr_data;
    logic [31:0] rd_hold;
    logic [31:0] rd_mux;

    // bank storage
    logic [15:0] depth_offset;
    logic [31:0] offset_rsvd;
    logic [31:0] temporal_blur;
    logic [12:0] mci_thresh;
    logic [8:0]  mf_weight;
    logic [15:0] mf_low;
    logic [31:0] out_format;
    logic        boot_status;
    logic [1:0]  fcnt;

    dor_mci_if mci ();

    wire byte_done = bits == 4'h8;
    wire addr_hit  = sh[7:1] == DEV_ADDR;
    wire drive_low = st == S_ADDR_ACK || st == S_RX_ACK || (st == S_TX && !tx[7]);
    assign sda_o    = 1'b0;
    assign sda_oe_n = !drive_low;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st   <= S_IDLE;
            bits <= 4'h0;
            sh   <= 8'h00;
            tx   <= 8'hFF;
            rw   <= 1'b0;
            nack <= 1'b0;
            bidx <= 3'h0;
            tn   <= 2'h0;
        end else if (bus_start) begin
            st   <= S_ADDR;
            bits <= 4'h0;
            bidx <= 3'h0;
        end else if (bus_stop) begin
            st <= S_IDLE;
        end else if (scl_rise) begin
            if (st == S_ADDR || st == S_RX || st == S_TX)
                bits <= bits + 1'b1;
            if (st == S_ADDR || st == S_RX)
                sh <= {sh[6:0], sda_s2};
            if (st == S_TX_ACK)
                nack <= sda_s2;
        end else if (scl_fall) begin
            unique case (st)
                S_IDLE: st <= S_IDLE;
                S_ADDR: begin
                    if (byte_done) begin
                        st <= addr_hit ? S_ADDR_ACK : S_IDLE;
                        rw <= sh[0];
                    end
                end
                S_ADDR_ACK: begin
                    bits <= 4'h0;
                    tn   <= 2'h1;
                    tx   <= rd_mux[31:24];
                    st   <= rw ? S_TX : S_RX;
                end
                S_RX: begin
                    if (byte_done) begin
                        st   <= S_RX_ACK;
                        bidx <= (bidx == 3'h5) ? 3'h2 : bidx + 1'b1;
                    end
                end
                S_RX_ACK: begin
                    st   <= S_RX;
                    bits <= 4'h0;
                end
                S_TX: begin
                    tx <= {tx[6:0], 1'b1};
                    if (byte_done)
                        st <= S_TX_ACK;
                end
                S_TX_ACK: begin
                    bits <= 4'h0;
                    tn   <= tn + 1'b1;
                    st   <= nack ? S_IDLE : S_TX;
                    unique case (tn)
                        2'h0: tx <= rd_mux[31:24];
                        2'h1: tx <= rd_hold[23:16];
                        2'h2: tx <= rd_hold[15:8];
                        2'h3: tx <= rd_hold[7:0];
                    endcase
                end
            endcase
        end
    end

    // address pointer, write assembly and read word capture
    wire rx_byte = scl_fall && st == S_RX && byte_done && !bus_start && !bus_stop;
    wire tx_word = scl_fall && st == S_TX && byte_done && tn == 2'h0;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ptr     <= 16'h0000;
            wd      <= 24'h0;
            wr_stb  <= 1'b0;
            wr_data <= 32'h0;
            rd_hold <= 32'h0;
        end else begin
            wr_stb <= rx_byte && bidx == 3'h5;
            if (rx_byte) begin
                unique case (bidx)
                    3'h0: ptr[15:8] <= sh;
                    3'h1: ptr[7:0]  <= sh;
                    3'h5: wr_data   <= {wd, sh};
                    default: wd     <= {wd[15:0], sh};
                endcase
            end
            if (scl_fall && st == S_ADDR_ACK)
                rd_hold <= rd_mux;
            else if (scl_fall && st == S_TX_ACK && tn == 2'h0)
                rd_hold <= rd_mux;
            if (wr_stb || tx_word)
                ptr <= ptr + 1'b1;
        end
    end

    // register writes; bits 22:16 of the multi-frequency word, the unused high bits of offset and threshold, and read-only words ignore the host
    wire wr_go = wr_stb;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            depth_offset  <= RST_GLOBAL_OFFSET;
            offset_rsvd   <= RST_OFFSET_RSVD;
            temporal_blur <= RST_TEMPORAL_BLUR;
            mci_thresh    <= RST_MCI_THRESH;
            mf_weight     <= RST_MF_WEIGHT;
            mf_low        <= 16'h0000;
            out_format    <= RST_OUT_FORMAT;
        end else if (wr_go) begin
            if (ptr == OFS_GLOBAL_OFFSET)
                depth_offset <= wr_data[15:0]; // R01
            if (ptr == OFS_OFFSET_RSVD)
                offset_rsvd <= wr_data; // R15
            if (ptr == OFS_TEMPORAL_BLUR)
                temporal_blur <= wr_data; // R02
            if (ptr == OFS_MCI_THRESH)
                mci_thresh <= wr_data[12:0];
            if (ptr == OFS_MULTIFREQ) begin
                mf_weight <= wr_data[31:MF_W_LSB]; // R03
                mf_low    <= wr_data[15:0]; // R04
            end
            if (ptr == OFS_OUT_FORMAT)
                out_format <= wr_data; // R08 R12
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        unique case (ptr)
            OFS_GLOBAL_OFFSET: rd_mux = {16'h0, depth_offset};
            OFS_OFFSET_RSVD:   rd_mux = offset_rsvd;
            OFS_TEMPORAL_BLUR: rd_mux = temporal_blur;
            OFS_MCI_THRESH:    rd_mux = {19'h0, mci_thresh};
            OFS_MULTIFREQ:     rd_mux = {mf_weight, MF_FIXED, mf_low}; // R04
            OFS_FW_REV:        rd_mux = {4'h0, FW_REV, 16'h0};
            OFS_OUT_FORMAT:    rd_mux = out_format;
            OFS_BOOT_STATUS:   rd_mux = {31'h0, boot_status}; // R13
            OFS_MCI_FLAGS:     rd_mux = {28'h0, mci.flags}; // R07
            default:           rd_mux = 32'h0;
        endcase
    end

    // boot status latches once and drives the pin
    always_ff @(posedge ref_clk) begin
        if (srst)
            boot_status <= 1'b0;
        else if (boot_done_in)
            boot_status <= 1'b1; // R13
    end
    assign boot_complete = boot_status; // R14

    // depth path with signed offset, clamped to the unsigned range
    wire signed [17:0] depth_sum = $signed({2'b00, depth_in})
                                 + $signed({{2{depth_offset[15]}}, depth_offset});
    wire [15:0] sat_depth = depth_sum[17] ? 16'h0000 :
                            depth_sum[16] ? 16'hFFFF : depth_sum[15:0];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            depth_out_valid <= 1'b0;
            depth_out       <= 16'h0000;
        end else begin
            depth_out_valid <= depth_in_valid;
            if (depth_in_valid)
                depth_out <= sat_depth; // R01
        end
    end

    // output layout per resolution mode
    function automatic logic [11:0] mode_width(input logic [3:0] m);
        unique case (m)
            MODE_FOUR: mode_width = WIDTH_FOUR;
            MODE_ZA:   mode_width = WIDTH_ZA;
            MODE_Z:    mode_width = WIDTH_Z;
            default:   mode_width = 12'h000;
        endcase
    endfunction

    // frame-rate divider: keep 1 of 1, 2 or 4 sensor frames
    function automatic logic [1:0] rate_mask(input logic [1:0] r);
        unique case (r)
            RATE_15:  rate_mask = 2'h1;
            RATE_7P5: rate_mask = 2'h3;
            default:  rate_mask = 2'h0;
        endcase
    endfunction

    wire [3:0] tx_mode  = out_format[31:MODE_LSB];
    wire [1:0] rate_sel = out_format[RATE_LSB+1:RATE_LSB];
    wire [1:0] keep_msk = rate_mask(rate_sel);
    assign frame_keep = frame_start_in && (fcnt & keep_msk) == 2'h0; // R11
    always_ff @(posedge ref_clk) begin
        if (srst)
            fcnt <= 2'h0;
        else if (frame_start_in)
            fcnt <= fcnt + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            line_width       <= 12'h000;
            line_count       <= 12'h000;
            hdelay           <= 12'h000;
            vdelay           <= 12'h000;
            depth_radial     <= 1'b0;
            chan_intensity   <= 1'b0;
            temporal_weight  <= 8'h00;
            multifreq_weight <= 9'h000;
            multifreq_enable <= 1'b0;
        end else begin
            line_width       <= mode_width(tx_mode); // R08
            line_count       <= (mode_width(tx_mode) == 12'h000) ? 12'h000 : LINES_OUT;
            hdelay           <= out_format[11:0]; // R12
            vdelay           <= out_format[VDLY_LSB+11:VDLY_LSB]; // R12
            depth_radial     <= out_format[0]; // R09
            chan_intensity   <= out_format[1]; // R10
            temporal_weight  <= temporal_blur[7:0]; // R02
            multifreq_weight <= mf_weight; // R03
            multifreq_enable <= mf_weight != MF_DISABLE; // R03
        end
    end

    assign mci.valid     = depth_in_valid;
    assign mci.area      = depth_area;
    assign mci.value     = depth_in;
    assign mci.frame_end = frame_end;
    assign mci.thresh    = mci_thresh;

    dor_mci_area #(.AVG_LOG2(AVG_LOG2)) u_mci (
        .ref_clk (ref_clk),
        .srst    (srst),
        .mci     (mci)
    );

    a_depth_offset: assert property (@(posedge ref_clk) disable iff (srst) // R01
        depth_in_valid |=> depth_out_valid && depth_out == $past(sat_depth))
        else $error("depth output not offset");
    a_mf_disable: assert property (@(posedge ref_clk) disable iff (srst) // R03
        (mf_weight == MF_DISABLE) |=> !multifreq_enable)
        else $error("multi-frequency not disabled");
    a_mf_fixed_read: assert property (@(posedge ref_clk) disable iff (srst) // R04
        (ptr == OFS_MULTIFREQ) |-> rd_mux[22:16] == MF_FIXED)
        else $error("fixed field changed");
    a_mode_width: assert property (@(posedge ref_clk) disable iff (srst) // R08
        (tx_mode == MODE_Z) [*2] |-> line_width == WIDTH_Z)
        else $error("layout width wrong");
    a_rate_skip: assert property (@(posedge ref_clk) disable iff (srst) // R11
        (frame_keep && rate_sel == RATE_7P5) ##[1:2] (frame_start_in && rate_sel == RATE_7P5)
        |-> !frame_keep) else $error("frame kept too often");
    a_rate_full: assert property (@(posedge ref_clk) disable iff (srst) // R11
        (frame_start_in && rate_sel == 2'h3) |-> frame_keep)
        else $error("30 fps frame dropped");
    a_boot_pin: assert property (@(posedge ref_clk) disable iff (srst) // R14
        boot_done_in |=> boot_complete [*3]) else $error("boot pin not held");
    a_addr_ack: assert property (@(posedge ref_clk) disable iff (srst)
        (st == S_ADDR && scl_fall && byte_done && addr_hit && !bus_start && !bus_stop)
        |=> !sda_oe_n) else $error("address not acknowledged");
    a_write_lands: assert property (@(posedge ref_clk) disable iff (srst) // R12
        (wr_stb && ptr == OFS_OUT_FORMAT) |=> ##1 hdelay == $past(wr_data[11:0], 2))
        else $error("delay write lost");
endmodule : dor_regs
